// [beam_leveler_defines.svh]
// Constants for the beam leveler motor control
`ifndef BEAM_LEVELER_DEFINES_SVH
`define BEAM_LEVELER_DEFINES_SVH
`define DRIVE_LEVEL_FULL 2'h3
`define DRIVE_LEVEL_REDUCED 2'h1
`define DRIVE_LEVEL_OFF 2'h0
`endif

// [beam_leveler_pkg.sv]
// Types for the beam leveler motor control
package beam_leveler_pkg;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_RUN = 3'b010,
        ST_HOLD = 3'b100
    } ctrl_state_e;
    typedef logic [1:0] drive_level_t;
endpackage : beam_leveler_pkg

// [fault_qualifier.sv]
// Combines the setpoint fault inputs into one registered stop level
`timescale 1ns/10ps
`default_nettype none
module fault_qualifier (
    input wire logic clk,
    input wire logic srst,
    input wire logic broken_wire,
    input wire logic set_short_batt,
    input wire logic set_short_gnd,
    output logic setpoint_fault
);
    wire any_fault;
    assign any_fault = broken_wire | set_short_batt | set_short_gnd;
    always_ff @(posedge clk)
    begin
        if (srst)
            setpoint_fault <= 1'b1;
        else
            setpoint_fault <= any_fault;
    end
endmodule : fault_qualifier
`default_nettype wire

// [beam_leveler.sv]
// Beam leveler motor control: on/off position loop with hysteresis and protections
`timescale 1ns/10ps
`default_nettype none
`include "beam_leveler_defines.svh"
module beam_leveler (
    input wire logic clk,
    input wire logic srst,
    input wire logic under_voltage,
    input wire logic over_voltage,
    input wire logic over_temp,
    input wire logic broken_wire,
    input wire logic set_short_batt,
    input wire logic set_short_gnd,
    input wire logic pos_transient,
    input wire logic error_above_high_ref,
    input wire logic error_below_low_ref,
    input wire logic setpoint_above_feedback,
    output logic motor_drive_a,
    output logic motor_drive_b,
    output logic drive_enable,
    output beam_leveler_pkg::drive_level_t drive_level,
    output logic ref_high,
    output logic motor_running,
    output logic setpoint_fault_out
);
    import beam_leveler_pkg::*;

    ctrl_state_e state_reg;
    ctrl_state_e state_next;
    logic dir_up_reg;
    logic latched_a_reg;
    logic latched_b_reg;
    logic transient_d_reg;
    logic armed_reg;
    logic setpoint_fault;

    fault_qualifier u_fault (
        .clk(clk),
        .srst(srst),
        .broken_wire(broken_wire),
        .set_short_batt(set_short_batt),
        .set_short_gnd(set_short_gnd),
        .setpoint_fault(setpoint_fault)
    );

    // Any supply or setpoint condition that forbids rotation; faults go through a register, so a
    // direct term keeps the stop from lagging by one cycle
    wire stop_now;
    wire transient_start;
    wire start_run;
    wire end_run;
    wire run_next;
    wire dir_next;
    wire a_next;
    wire b_next;
    wire en_next;
    drive_level_t level_next;

    assign stop_now = under_voltage | over_voltage | broken_wire | set_short_batt
        | set_short_gnd | setpoint_fault;
    assign transient_start = pos_transient & ~transient_d_reg;
    assign start_run = (state_reg == ST_IDLE) & error_above_high_ref & ~stop_now
        & ~pos_transient;
    assign end_run = (state_reg == ST_RUN) & (error_below_low_ref | stop_now);

    always_comb
    begin
        state_next = state_reg;
        unique case (state_reg)
            ST_IDLE:
            begin
                if (pos_transient)
                    state_next = ST_HOLD;
                else if (start_run)
                    state_next = ST_RUN;
            end
            ST_RUN:
            begin
                if (pos_transient)
                    state_next = ST_HOLD;
                else if (end_run)
                    state_next = ST_IDLE;
            end
            ST_HOLD:
            begin
                // Returns to idle so the loop re-evaluates with the high reference
                if (!pos_transient)
                    state_next = ST_IDLE;
            end
        endcase
    end

    assign run_next = (state_next == ST_RUN);
    assign dir_next = start_run ? setpoint_above_feedback : dir_up_reg;
    // Brake is both outputs low, so the motor terminals are shorted
    assign a_next = run_next & dir_next;
    assign b_next = run_next & ~dir_next;
    // Outputs released on over-voltage or transient; brake needs the stage on
    assign en_next = ~over_voltage & (state_next != ST_HOLD);
    assign level_next = !en_next ? `DRIVE_LEVEL_OFF
        : (over_temp ? `DRIVE_LEVEL_REDUCED : `DRIVE_LEVEL_FULL);

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            state_reg <= ST_IDLE;
            dir_up_reg <= 1'b0;
            transient_d_reg <= 1'b0;
            latched_a_reg <= 1'b0;
            latched_b_reg <= 1'b0;
            armed_reg <= 1'b0;
        end
        else
        begin
            state_reg <= state_next;
            dir_up_reg <= dir_next;
            transient_d_reg <= pos_transient;
            armed_reg <= 1'b1;
            if (transient_start)
            begin
                latched_a_reg <= motor_drive_a;
                latched_b_reg <= motor_drive_b;
            end
        end
    end

    // During a transient the pins keep the latched stage state while drive is off
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            motor_drive_a <= 1'b0;
            motor_drive_b <= 1'b0;
            drive_enable <= 1'b0;
            drive_level <= `DRIVE_LEVEL_OFF;
            ref_high <= 1'b1;
            motor_running <= 1'b0;
            setpoint_fault_out <= 1'b0;
        end
        else
        begin
            motor_drive_a <= (state_next == ST_HOLD)
                ? (transient_start ? motor_drive_a : latched_a_reg) : a_next;
            motor_drive_b <= (state_next == ST_HOLD)
                ? (transient_start ? motor_drive_b : latched_b_reg) : b_next;
            drive_enable <= en_next;
            drive_level <= level_next;
            ref_high <= ~run_next;
            motor_running <= run_next;
            // The fault register leaves reset set to hold off a start; that
            // must not show as a false fault pulse on the status pin
            setpoint_fault_out <= setpoint_fault & armed_reg;
        end
    end

    a_uv_brake: assert property (@(posedge clk) disable iff (srst)
        under_voltage && !over_voltage && !pos_transient
        |=> motor_drive_a == motor_drive_b && drive_enable && !motor_running)
        else $error("motor energised under low supply");
    a_ov_release: assert property (@(posedge clk) disable iff (srst)
        over_voltage |=> !drive_enable && drive_level == 2'h0)
        else $error("outputs not released on over-voltage");
    a_hot_reduce: assert property (@(posedge clk) disable iff (srst)
        over_temp && !over_voltage && !pos_transient |=> drive_level == 2'h1)
        else $error("drive not reduced when hot");
    a_cool_full: assert property (@(posedge clk) disable iff (srst)
        !over_temp && !over_voltage && !pos_transient |=> drive_level == 2'h3)
        else $error("full drive not restored");
    a_wire_stop: assert property (@(posedge clk) disable iff (srst)
        (broken_wire || set_short_batt || set_short_gnd) && !pos_transient
        |=> !motor_running && motor_drive_a == motor_drive_b)
        else $error("motor turns with setpoint fault");
    a_fault_flag: assert property (@(posedge clk) disable iff (srst)
        broken_wire || set_short_batt || set_short_gnd |=> ##1 setpoint_fault_out)
        else $error("setpoint fault not flagged");
    a_trans_off: assert property (@(posedge clk) disable iff (srst)
        pos_transient |=> !drive_enable && !motor_running)
        else $error("drive on during transient");
    a_trans_hold: assert property (@(posedge clk) disable iff (srst)
        pos_transient && $past(pos_transient)
        |=> $stable(motor_drive_a) && $stable(motor_drive_b))
        else $error("latched stage state changed");
    a_start_ref: assert property (@(posedge clk) disable iff (srst)
        $rose(motor_running) |-> !ref_high && $past(ref_high))
        else $error("reference not switched low at start");
    a_keep_run: assert property (@(posedge clk) disable iff (srst)
        motor_running && !error_below_low_ref && !stop_now && !pos_transient
        |=> motor_running && !ref_high)
        else $error("run or low reference dropped early");
    a_stop_ref: assert property (@(posedge clk) disable iff (srst)
        motor_running && error_below_low_ref |=> ref_high && !motor_running)
        else $error("run not ended below low reference");
    a_start_dir: assert property (@(posedge clk) disable iff (srst)
        !motor_running && start_run |=> motor_drive_a == $past(setpoint_above_feedback)
        && motor_drive_b != motor_drive_a)
        else $error("wrong start polarity");
    a_idle_brake: assert property (@(posedge clk) disable iff (srst)
        !motor_running && drive_enable |-> motor_drive_a == motor_drive_b)
        else $error("idle without brake");
    c_run_up: cover property (@(posedge clk) disable iff (srst)
        $rose(motor_running) && motor_drive_a);
    c_run_down: cover property (@(posedge clk) disable iff (srst)
        $rose(motor_running) && motor_drive_b);
    c_transient: cover property (@(posedge clk) disable iff (srst)
        motor_running ##1 pos_transient);
    c_hot_run: cover property (@(posedge clk) disable iff (srst)
        motor_running && drive_level == 2'h1);
endmodule : beam_leveler
`default_nettype wire

// [motor_model.sv]
// Behavioural DC motor with a coupled position feedback potentiometer
`timescale 1ns/10ps
`default_nettype none
module motor_model (
    input wire logic clk,
    input wire logic drive_a,
    input wire logic drive_b,
    input wire logic drive_on,
    input wire logic [7:0] target,
    output logic sp_above_fb,
    output logic err_hi,
    output logic err_lo
);
    logic [7:0] pos_reg = 8'h64;
    logic [7:0] err;
    // Released or braked outputs leave the shaft where it is
    always_ff @(posedge clk)
    begin
        if (drive_on && drive_a && !drive_b)
            pos_reg <= pos_reg + 8'h01;
        else if (drive_on && drive_b && !drive_a)
            pos_reg <= pos_reg - 8'h01;
    end
    assign sp_above_fb = target > pos_reg;
    assign err = sp_above_fb ? target - pos_reg : pos_reg - target;
    assign err_hi = err > 8'h08;
    assign err_lo = err < 8'h02;
endmodule : motor_model
`default_nettype wire

// [beam_level_motor_control_test.sv]
// Self-checking testbench for the beam leveler motor control
`timescale 1ns/10ps
`default_nettype none
`include "beam_leveler_defines.svh"
module beam_level_motor_control_test;
    import beam_leveler_pkg::*;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic uv = 1'b0, ov = 1'b0, ot = 1'b0, bw = 1'b0, sb = 1'b0, sg = 1'b0, pt = 1'b0;
    logic [7:0] target = 8'h64;
    logic a, b, en, rh, run, sp, hi, lo, fo;
    drive_level_t lvl;
    int n_errors = 0;
    int compares = 0;
    int cycles = 0;
    beam_leveler dut_u (.clk(clk), .srst(srst), .under_voltage(uv), .over_voltage(ov),
        .over_temp(ot), .broken_wire(bw), .set_short_batt(sb), .set_short_gnd(sg),
        .pos_transient(pt), .error_above_high_ref(hi), .error_below_low_ref(lo),
        .setpoint_above_feedback(sp), .motor_drive_a(a), .motor_drive_b(b),
        .drive_enable(en), .drive_level(lvl), .ref_high(rh), .motor_running(run),
        .setpoint_fault_out(fo));
    motor_model motor_u (.clk(clk), .drive_a(a), .drive_b(b), .drive_on(en),
        .target(target), .sp_above_fb(sp), .err_hi(hi), .err_lo(lo));
    initial
        forever #4 clk = ~clk;
    task automatic wrap_up;
        $display("errors %0d compares %0d", n_errors, compares);
        if (n_errors == 0 && compares > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : wrap_up
    task automatic chk(input logic [1:0] got, input logic [1:0] exp);
        compares++;
        if (got !== exp)
        begin
            n_errors++;
            $display("MISMATCH %0t got %0h exp %0h", $time, got, exp);
        end
    endtask : chk
    // Bounded wait; a run that never comes shows up as a mismatch
    task automatic wait_run(input logic v);
        for (int i = 0; i < 400 && run !== v; i++)
            @(negedge clk);
        chk({1'b0, run}, {1'b0, v});
    endtask : wait_run
    task automatic move(input logic [7:0] t, input logic up);
        target = t;
        wait_run(1'b1);
        chk({a, b}, {up, !up});
        chk({rh, en}, 2'b01);
        chk(lvl, `DRIVE_LEVEL_FULL);
        wait_run(1'b0);
        chk({a ^ b, rh}, 2'b01);
        repeat (3) @(negedge clk);
        chk({run, a ^ b}, 2'b00);
    endtask : move
    task automatic small_error;
        target = 8'h55;
        repeat (10) @(negedge clk);
        chk({run, rh}, 2'b01);
    endtask : small_error
    task automatic supply;
        uv = 1'b1;
        target = 8'h90;
        repeat (20) @(negedge clk);
        chk({run, a ^ b}, 2'b00);
        chk({en, a}, 2'b10);
        uv = 1'b0;
        ov = 1'b1;
        repeat (3) @(negedge clk);
        chk({run, en}, 2'b00);
        ov = 1'b0;
        wait_run(1'b1);
        ot = 1'b1;
        repeat (2) @(negedge clk);
        chk(lvl, `DRIVE_LEVEL_REDUCED);
        ot = 1'b0;
        repeat (2) @(negedge clk);
        chk(lvl, `DRIVE_LEVEL_FULL);
        wait_run(1'b0);
    endtask : supply
    task automatic faults;
        for (int k = 0; k < 3; k++)
        begin
            target = k == 1 ? 8'h40 : 8'hb0;
            wait_run(1'b1);
            {bw, sb, sg} = 3'b100 >> k;
            repeat (4) @(negedge clk);
            chk({run, a ^ b}, 2'b00);
            chk({en, rh}, 2'b11);
            chk({1'b0, fo}, 2'b01);
            {bw, sb, sg} = 3'b000;
            wait_run(1'b1);
            chk({run, fo}, 2'b10);
            wait_run(1'b0);
        end
    endtask : faults
    task automatic transient;
        target = 8'h40;
        wait_run(1'b1);
        @(negedge clk);
        pt = 1'b1;
        repeat (3) @(negedge clk);
        chk({a, b}, 2'b01);
        chk({1'b0, en}, 2'b00);
        chk(lvl, `DRIVE_LEVEL_OFF);
        pt = 1'b0;
        @(negedge clk);
        chk({en, a ^ b}, 2'b10);
        wait_run(1'b1);
        wait_run(1'b0);
    endtask : transient
    // Cuts a hang short; the ceiling is some thirty times the expected run
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            n_errors++;
            wrap_up;
        end
    end
    initial
    begin
        repeat (3) @(negedge clk);
        srst = 1'b0;
        @(negedge clk);
        chk({en, fo}, 2'b10);
        @(negedge clk);
        chk({rh, run}, 2'b10);
        move(8'h80, 1'b1);
        move(8'h50, 1'b0);
        small_error;
        supply;
        faults;
        transient;
        wrap_up;
    end
endmodule : beam_level_motor_control_test
`default_nettype wire
